// ### rtl/ppv_port.sv
// Parallel video port: APB register side and port-clock link side.
// Assumes the port clock comes from the far party and may stop between
// frames; config may change only while the port is disabled.
// Summary of operation
// - The port has one input clock, three frame sync lines, 16 data lines.
// - Each frame sync line can be set as an input or as a driven output.
// - General-purpose mode moves up to 16 bits one direction at a time.
// - Video mode moves 8 or 10 bit samples one direction at a time.
// - Video mode decodes the embedded line and field start preambles.
// - In input mode frame syncs and data are all inputs.
// - In frame capture mode the port drives syncs and samples the data.
// - In output mode the port drives the data and up to three syncs.
// - Active-video mode keeps only active samples and drops blanking.
// - Blanking mode keeps only vertical blanking samples.
// - Entire-field mode keeps every sample unfiltered.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ppv_port (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [7:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic port_clock_in, // Link clock from the far party
  input wire logic [15:0] data_in, // Data pins, input side
  output logic [15:0] data_out, // Data pins, output side
  output logic data_oe, // Data pins drive enable
  input wire logic [2:0] fs_in, // Frame sync pins, input side
  output logic [2:0] fs_out, // Frame sync pins, output side
  output logic [2:0] fs_oe // Frame sync drive enables
);

  typedef struct packed {
    logic [8:0] ctrl;
    logic [15:0] llen;
    logic [15:0] flin;
    logic [15:0] rx_data;
    logic rx_v;
    logic ovr;
    logic line_start_preamble;
    logic sof;
    logic [15:0] tx_hold;
    logic tx_tgl;
    logic rx_ack;
    logic rx_seen;
    logic ovr_seen;
    logic sol_seen;
    logic sof_seen;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ppv_sys_t;

  typedef struct packed {
    logic [15:0] d0, d1, d2;
    logic o0, o1, o2;
    logic k0, k1, k2;
    logic fld, vb, hb;
    logic [15:0] rx_hold;
    logic rx_req;
    logic ovr_tgl, sol_tgl, sof_tgl;
    logic tx_ack;
    logic [15:0] dout;
    logic doe;
    logic [15:0] px, ln;
    logic [2:0] fso, fsoe;
  } ppv_lnk_t;

  localparam ppv_sys_t SYS_RST = '{ctrl: ppv_pkg::CTRL_RST,
    llen: ppv_pkg::LLEN_RST, flin: ppv_pkg::FLIN_RST, default: '0};

  ppv_sys_t s_reg;
  ppv_sys_t s_next;
  ppv_lnk_t l_reg;
  ppv_lnk_t l_next;

  // Sample code byte: top eight bits of a 10-bit or 8-bit sample
  function automatic logic [7:0] code8(input logic [15:0] s,
                                       input logic ten);
    return ten ? s[9:2] : s[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Crossings: events as toggles, status as quasi-static levels
  logic [6:0] lsq;
  logic [42:0] csq;

  ppv_sync2 #(.W(7)) u_to_sys (
    .clk(clk_sys),
    .rst(rst),
    .d({l_reg.rx_req, l_reg.ovr_tgl, l_reg.sol_tgl, l_reg.sof_tgl,
        l_reg.tx_ack, l_reg.fld, l_reg.vb}),
    .q(lsq)
  );

  ppv_sync2 #(.W(43)) u_to_lnk (
    .clk(port_clock_in),
    .rst(rst),
    .d({s_reg.rx_ack, s_reg.tx_tgl, s_reg.ctrl, s_reg.llen, s_reg.flin}),
    .q(csq)
  );

  logic q_rx, q_ovr, q_sol, q_sof, q_txa, q_fld, q_vb;
  assign {q_rx, q_ovr, q_sol, q_sof, q_txa, q_fld, q_vb} = lsq;

  logic c_rxa, c_txt;
  logic [8:0] c_ctrl;
  logic [15:0] c_llen, c_flin;
  assign {c_rxa, c_txt, c_ctrl, c_llen, c_flin} = csq;

  logic tx_busy;
  assign tx_busy = s_reg.tx_tgl != q_txa;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: answer prepared in setup, ready in the access cycle
  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    // Writes and pops take effect at the completing edge
    if (psel && penable && s_reg.pready) begin
      if (pwrite) begin
        case (paddr)
          ppv_pkg::A_CTRL: s_next.ctrl = pwdata[8:0];
          ppv_pkg::A_STAT: begin
            if (pwdata[ppv_pkg::S_OVR]) s_next.ovr = 1'b0;
            if (pwdata[ppv_pkg::S_SOL]) s_next.line_start_preamble = 1'b0;
            if (pwdata[ppv_pkg::S_SOF]) s_next.sof = 1'b0;
          end
          ppv_pkg::A_TXD: begin
            // A word written while the last is still crossing is dropped
            if (!tx_busy) begin
              s_next.tx_hold = pwdata[15:0];
              s_next.tx_tgl = ~s_reg.tx_tgl;
            end
          end
          ppv_pkg::A_LLEN: s_next.llen = pwdata[15:0];
          ppv_pkg::A_FLIN: s_next.flin = pwdata[15:0];
          default: ;
        endcase
      end else if (paddr == ppv_pkg::A_RXD) begin
        s_next.rx_v = 1'b0;
      end
    end
    // Setup cycle: decode and register the answer
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      s_next.prdata = '0;
      case (paddr)
        ppv_pkg::A_CTRL: s_next.prdata = {23'h000000, s_reg.ctrl};
        ppv_pkg::A_STAT: s_next.prdata = {25'h0000000, s_reg.sof,
          s_reg.line_start_preamble, q_vb, q_fld, tx_busy, s_reg.ovr, s_reg.rx_v};
        ppv_pkg::A_RXD: s_next.prdata = {16'h0000, s_reg.rx_data};
        ppv_pkg::A_TXD: s_next.prdata = {16'h0000, s_reg.tx_hold};
        ppv_pkg::A_LLEN: s_next.prdata = {16'h0000, s_reg.llen};
        ppv_pkg::A_FLIN: s_next.prdata = {16'h0000, s_reg.flin};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    // Link events come last so a set beats a same-cycle clear
    if (q_rx != s_reg.rx_seen) begin
      s_next.rx_seen = q_rx;
      if (s_next.rx_v) s_next.ovr = 1'b1;
      s_next.rx_data = l_reg.rx_hold;
      s_next.rx_v = 1'b1;
      s_next.rx_ack = ~s_reg.rx_ack;
    end
    if (q_ovr != s_reg.ovr_seen) begin
      s_next.ovr_seen = q_ovr;
      s_next.ovr = 1'b1;
    end
    if (q_sol != s_reg.sol_seen) begin
      s_next.sol_seen = q_sol;
      s_next.line_start_preamble = 1'b1;
    end
    if (q_sof != s_reg.sof_seen) begin
      s_next.sof_seen = q_sof;
      s_next.sof = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= SYS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;

  ////////////////////////////////////////////////////////////////////////
  // Link side decode of the configuration
  ppv_pkg::ppv_mode_t mode;
  logic en, ten, is_itu, cap_ok, fsgen, gate, det, drop, drive;
  logic [7:0] xy;

  assign mode = ppv_pkg::ppv_mode_t'(c_ctrl[ppv_pkg::C_MODE +: 3]);
  assign en = c_ctrl[ppv_pkg::C_EN];
  assign ten = c_ctrl[ppv_pkg::C_TEN];
  assign xy = code8(data_in, ten);

  // Per-mode capture gate; unused codes leave the port idle
  always_comb begin
    is_itu = 1'b0;
    cap_ok = 1'b0;
    fsgen = 1'b0;
    gate = 1'b0;
    unique case (mode)
      ppv_pkg::GP_IN: begin
        cap_ok = 1'b1;
        gate = fs_in[0];
      end
      ppv_pkg::GP_CAP: begin
        cap_ok = 1'b1;
        fsgen = 1'b1;
        gate = 1'b1;
      end
      ppv_pkg::GP_OUT: fsgen = 1'b1;
      ppv_pkg::ITU_ACT: begin
        is_itu = 1'b1;
        cap_ok = 1'b1;
        gate = !l_reg.vb && !l_reg.hb;
      end
      ppv_pkg::ITU_VBI: begin
        is_itu = 1'b1;
        cap_ok = 1'b1;
        gate = l_reg.vb;
      end
      ppv_pkg::ITU_ALL: begin
        is_itu = 1'b1;
        cap_ok = 1'b1;
        gate = 1'b1;
      end
      default: ;
    endcase
  end

  // One direction at a time: driving the data pins stops capture
  assign drive = en && (mode == ppv_pkg::GP_OUT ||
    (is_itu && c_ctrl[ppv_pkg::C_DIR]));

  // Preamble: FF 00 00 in the pipe, status byte on the pins now
  assign det = is_itu && l_reg.o0 && l_reg.o1 && l_reg.o2 &&
    code8(l_reg.d2, ten) == ppv_pkg::CODE_FF &&
    code8(l_reg.d1, ten) == ppv_pkg::CODE_00 &&
    code8(l_reg.d0, ten) == ppv_pkg::CODE_00;
  assign drop = det && mode != ppv_pkg::ITU_ALL;

  ////////////////////////////////////////////////////////////////////////
  // Link logic on the port clock: capture pipe, sync generator, output
  always_comb begin
    l_next = l_reg;
    l_next.doe = drive;
    if (en && cap_ok && !drive) begin
      // Oldest sample leaves the three-deep pipe towards the system side
      if (l_reg.o2 && l_reg.k2 && !drop) begin
        if (l_reg.rx_req == c_rxa) begin
          l_next.rx_hold = l_reg.d2;
          l_next.rx_req = ~l_reg.rx_req;
        end else begin
          // Previous word still crossing: report instead of stalling
          l_next.ovr_tgl = ~l_reg.ovr_tgl;
        end
      end
      l_next.d2 = l_reg.d1;
      l_next.d1 = l_reg.d0;
      l_next.d0 = data_in;
      l_next.o2 = l_reg.o1;
      l_next.o1 = l_reg.o0;
      l_next.o0 = 1'b1;
      l_next.k2 = l_reg.k1;
      l_next.k1 = l_reg.k0;
      l_next.k0 = gate;
      if (det) begin
        l_next.fld = xy[ppv_pkg::XY_F];
        l_next.vb = xy[ppv_pkg::XY_V];
        l_next.hb = xy[ppv_pkg::XY_H];
        if (!xy[ppv_pkg::XY_H]) l_next.sol_tgl = ~l_reg.sol_tgl;
        if (xy[ppv_pkg::XY_F] != l_reg.fld) begin
          l_next.sof_tgl = ~l_reg.sof_tgl;
        end
        // Preamble bytes never reach software in filtered modes
        if (drop) begin
          l_next.o0 = 1'b0;
          l_next.o1 = 1'b0;
          l_next.o2 = 1'b0;
        end
      end
    end else begin
      l_next.o0 = 1'b0;
      l_next.o1 = 1'b0;
      l_next.o2 = 1'b0;
    end
    // Transmit word handed over by toggle; hold is stable until acked
    if (c_txt != l_reg.tx_ack) begin
      l_next.dout = s_reg.tx_hold;
      l_next.tx_ack = c_txt;
    end
    // Sync generator: line pulse, frame pulse, first-line level
    if (en && fsgen) begin
      if (l_reg.px >= c_llen - 16'h0001) begin
        l_next.px = '0;
        l_next.ln = (l_reg.ln >= c_flin - 16'h0001) ? '0
                    : l_reg.ln + 16'h0001;
      end else begin
        l_next.px = l_reg.px + 16'h0001;
      end
      l_next.fso[0] = l_reg.px == '0;
      l_next.fso[1] = l_reg.px == '0 && l_reg.ln == '0;
      l_next.fso[2] = l_reg.ln == '0;
      l_next.fsoe = c_ctrl[ppv_pkg::C_FSD +: 3];
    end else begin
      l_next.px = '0;
      l_next.ln = '0;
      l_next.fso = '0;
      l_next.fsoe = '0;
    end
  end

  always_ff @(posedge port_clock_in or posedge rst) begin
    if (rst) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  assign data_out = l_reg.dout;
  assign data_oe = l_reg.doe;
  assign fs_out = l_reg.fso;
  assign fs_oe = l_reg.fsoe;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the link side
  a_input_no_drive: assert property (@(posedge port_clock_in)
    disable iff (rst) mode == ppv_pkg::GP_IN |=> fs_oe == 3'h0)
    else $error("sync driven in input mode");

  a_capture_syncs: assert property (@(posedge port_clock_in)
    disable iff (rst) en && mode == ppv_pkg::GP_CAP |=>
    fs_oe == $past(c_ctrl[7:5]) && !data_oe)
    else $error("capture mode sync or data drive wrong");

  a_output_drives: assert property (@(posedge port_clock_in)
    disable iff (rst) en && mode == ppv_pkg::GP_OUT |=> data_oe)
    else $error("output mode not driving data");

  a_one_direction: assert property (@(posedge port_clock_in)
    disable iff (rst) data_oe |-> ##1 !l_reg.o0)
    else $error("capture while driving");

  a_active_gate: assert property (@(posedge port_clock_in)
    disable iff (rst) mode == ppv_pkg::ITU_ACT && (l_reg.vb || l_reg.hb)
    |=> !l_reg.k0)
    else $error("blanking sample kept in active mode");

  a_vbi_gate: assert property (@(posedge port_clock_in)
    disable iff (rst) mode == ppv_pkg::ITU_VBI && !l_reg.vb
    |=> !l_reg.k0)
    else $error("active sample kept in blanking mode");

  a_field_keeps: assert property (@(posedge port_clock_in)
    disable iff (rst) en && mode == ppv_pkg::ITU_ALL && !drive
    |=> l_reg.o0 && l_reg.k0)
    else $error("sample lost in entire-field mode");

  a_preamble_kill: assert property (@(posedge port_clock_in)
    disable iff (rst) en && drop && !drive
    |=> !l_reg.o0 && !l_reg.o1 && !l_reg.o2)
    else $error("preamble left in pipe");

  a_line_start: assert property (@(posedge port_clock_in)
    disable iff (rst) en && det && !drive && !xy[4]
    |=> l_reg.sol_tgl != $past(l_reg.sol_tgl))
    else $error("line start not flagged");

  // Check on the system side
  a_word_arrives: assert property (@(posedge clk_sys)
    disable iff (rst) q_rx != s_reg.rx_seen
    |=> s_reg.rx_v && s_reg.rx_ack != $past(s_reg.rx_ack))
    else $error("received word not taken or acked");

endmodule

// ### rtl/ppv_pkg.sv
// Constants shared by the parallel video port files.
// Assumes a 32-bit APB with byte addresses and one word per register.
package ppv_pkg;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_RXD = 8'h08;
  localparam logic [7:0] A_TXD = 8'h0C;
  localparam logic [7:0] A_LLEN = 8'h10;
  localparam logic [7:0] A_FLIN = 8'h14;

  // Control field positions
  localparam int C_EN = 0;
  localparam int C_MODE = 1;
  localparam int C_TEN = 4;
  localparam int C_FSD = 5;
  localparam int C_DIR = 8;

  // Status field positions
  localparam int S_RXV = 0;
  localparam int S_OVR = 1;
  localparam int S_TXB = 2;
  localparam int S_FLD = 3;
  localparam int S_VBL = 4;
  localparam int S_SOL = 5;
  localparam int S_SOF = 6;

  // Reset values
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [15:0] LLEN_RST = 16'h0010;
  localparam logic [15:0] FLIN_RST = 16'h0008;

  // Embedded preamble bytes and flag positions in the status byte
  localparam logic [7:0] CODE_FF = 8'hFF;
  localparam logic [7:0] CODE_00 = 8'h00;
  localparam int XY_F = 6;
  localparam int XY_V = 5;
  localparam int XY_H = 4;

  // Port submodes
  typedef enum logic [2:0] {
    GP_IN = 3'b000,
    GP_CAP = 3'b001,
    GP_OUT = 3'b010,
    ITU_ACT = 3'b011,
    ITU_VBI = 3'b100,
    ITU_ALL = 3'b101
  } ppv_mode_t;

endpackage

// ### rtl/ppv_sync2.sv
// Two flip-flop synchroniser for levels and toggles.
// Assumes each bit is a level or toggle that is stable for several cycles.
`timescale 1ns/1ps
module ppv_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst, // Async reset, active high
  input wire logic [W-1:0] d, // Bits from the other domain
  output logic [W-1:0] q // Synchronised bits
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppv_sync_t;

  ppv_sync_t r_reg;
  ppv_sync_t r_next;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_comb begin
    r_next = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;

endmodule

// ### sim/ppv_far_end.sv
// Model of the far party: a video or converter source on the port pins.
// Assumes the bench calls its tasks; the link clock idles low between them.
`timescale 1ns/1ps
module ppv_far_end (
  output logic port_clock_in, // Link clock, stands still outside frames
  output logic [15:0] data_in, // Resolved data wire
  output logic [2:0] fs_in, // Resolved frame sync wires
  input wire logic [15:0] data_out, // Port data drive
  input wire logic data_oe, // Port data enable
  input wire logic [2:0] fs_out, // Port sync drive
  input wire logic [2:0] fs_oe // Port sync enables
);
  logic [15:0] drv_d = 16'h0000;
  logic [2:0] drv_fs = 3'h0;
  int pulses = 0;
  int frames = 0;
  initial port_clock_in = 1'b0;
  //////////////////////////////////////////////////////////////////////////
  // Wire level: whoever is enabled drives it, else our own value
  always_comb begin
    data_in = data_oe ? data_out : drv_d;
    for (int i = 0; i < 3; i++) begin
      fs_in[i] = fs_oe[i] ? fs_out[i] : drv_fs[i];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // One 80 ns link cycle; keeps the rate under half the system clock
  task automatic cyc(input logic [15:0] d, input logic [2:0] f);
    drv_d = d;
    drv_fs = f;
    #40 port_clock_in = 1'b1;
    if (fs_oe[0] && fs_out[0]) begin
      pulses++;
    end
    if (fs_oe[1] && fs_out[1]) begin
      frames++;
    end
    // Past the hold time the pins stop carrying the sampled word
    #20 drv_d = ~d;
    drv_fs = ~f;
    #20 port_clock_in = 1'b0;
  endtask
  // Embedded preamble, byte on data[9:2] in ten-bit mode
  task automatic pre(input logic [7:0] xy, input logic t);
    logic [7:0] b[4];
    b = '{8'hFF, 8'h00, 8'h00, xy};
    foreach (b[i]) begin
      cyc(t ? {6'h00, b[i], 2'b00} : {8'h00, b[i]}, 3'h0);
    end
  endtask
endmodule

// ### sim/ppv_port_bench.sv
// Self-checking bench for the parallel video port.
// Assumes the far party model above sits on the pins.
`timescale 1ns/1ps
module ppv_port_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, port_clock_in, data_oe, ev;
  logic [15:0] data_in, data_out;
  logic [2:0] fs_in, fs_out, fs_oe;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  ppv_port DUT (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_clock_in(port_clock_in),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .fs_in(fs_in), .fs_out(fs_out), .fs_oe(fs_oe));
  ppv_far_end far (.port_clock_in(port_clock_in), .data_in(data_in),
    .fs_in(fs_in), .data_out(data_out), .data_oe(data_oe),
    .fs_out(fs_out), .fs_oe(fs_oe));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////
  // Compare and APB master
  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Config changes only with the port disabled
  task automatic cfg(input logic [2:0] m, input logic [2:0] fsd,
                     input logic t);
    apb(1, ppv_pkg::A_CTRL, 32'h0);
    repeat (3) far.cyc(16'h0010, 3'h0);
    apb(1, ppv_pkg::A_CTRL, {23'h0, 1'b0, fsd, t, m, 1'b1});
    repeat (4) far.cyc(16'h0010, 3'h0);
  endtask
  // Drop whatever was caught and clear sticky status
  task automatic flush();
    apb(0, ppv_pkg::A_RXD, 32'h0);
    apb(1, ppv_pkg::A_STAT, 32'h0000_0062);
  endtask
  task automatic rx(input logic [15:0] exp, input string what);
    int n;
    n = 0;
    do begin
      apb(0, ppv_pkg::A_STAT, 32'h0);
      n++;
    end while (rv[ppv_pkg::S_RXV] !== 1'b1 && n < 30);
    apb(0, ppv_pkg::A_RXD, 32'h0);
    chk(rv, {16'h0, exp}, what);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    apb(0, ppv_pkg::A_CTRL, 32'h0);
    chk(rv, 32'h0, "ctrl reset");
    apb(0, ppv_pkg::A_LLEN, 32'h0);
    chk(rv, 32'h0000_0010, "line len reset");
    apb(0, ppv_pkg::A_FLIN, 32'h0);
    chk(rv, 32'h0000_0008, "frame lines reset");
    apb(0, 8'h18, 32'h0);
    chk({31'h0, ev}, 32'h1, "unmapped error");
    chk(rv, 32'h0, "unmapped data");
    // Short lines and frames so the sync counts see whole periods
    apb(1, ppv_pkg::A_LLEN, 32'h0000_0004);
    apb(1, ppv_pkg::A_FLIN, 32'h0000_0002);
    apb(0, ppv_pkg::A_LLEN, 32'h0);
    chk(rv, 32'h0000_0004, "line len write");
    apb(0, ppv_pkg::A_FLIN, 32'h0);
    chk(rv, 32'h0000_0002, "frame lines write");
  endtask
  task automatic t_gp_in();
    cfg(ppv_pkg::GP_IN, 3'h7, 0);
    chk({data_oe, fs_oe}, 4'h0, "input mode drives");
    flush();
    far.cyc(16'h0BAD, 3'h0);
    far.cyc(16'hA5C3, 3'h1);
    repeat (8) far.cyc(16'h0010, 3'h0);
    rx(16'hA5C3, "gp input word");
  endtask
  task automatic t_capture();
    cfg(ppv_pkg::GP_CAP, 3'h3, 0);
    chk({data_oe, fs_oe}, 4'h3, "capture drives");
    repeat (10) far.cyc(16'h7E81, 3'h0);
    flush();
    repeat (10) far.cyc(16'h7E81, 3'h0);
    rx(16'h7E81, "capture word");
  endtask
  task automatic t_gp_out();
    cfg(ppv_pkg::GP_OUT, 3'h7, 0);
    chk({data_oe, fs_oe}, 4'hF, "output drives");
    apb(1, ppv_pkg::A_TXD, 32'h0000_C35A);
    apb(0, ppv_pkg::A_STAT, 32'h0);
    chk(rv[ppv_pkg::S_TXB], 1'b1, "tx busy");
    // Link clock stands still, so this word must be refused
    apb(1, ppv_pkg::A_TXD, 32'h0000_1111);
    apb(0, ppv_pkg::A_TXD, 32'h0);
    chk(rv, 32'h0000_C35A, "busy write dropped");
    far.pulses = 0;
    far.frames = 0;
    repeat (40) far.cyc(16'h0010, 3'h0);
    chk(data_out, 16'hC35A, "tx word");
    chk(far.pulses, 10, "line pulses");
    chk(far.frames, 5, "frame pulses");
    apb(0, ppv_pkg::A_STAT, 32'h0);
    chk(rv[ppv_pkg::S_TXB], 1'b0, "tx done");
    cfg(3'h6, 3'h7, 0);
    chk({data_oe, fs_oe}, 4'h0, "idle mode drives");
  endtask
  task automatic t_itu_act();
    cfg(ppv_pkg::ITU_ACT, 3'h0, 0);
    far.pre(8'h90, 0);
    repeat (6) far.cyc(16'h0010, 3'h0);
    flush();
    far.pre(8'h80, 0);
    far.cyc(16'h005A, 3'h0);
    far.pre(8'h90, 0);
    repeat (8) far.cyc(16'h0010, 3'h0);
    rx(16'h005A, "active sample");
    apb(0, ppv_pkg::A_STAT, 32'h0);
    chk({rv[ppv_pkg::S_SOL], rv[ppv_pkg::S_OVR]}, 2'b10, "sol");
  endtask
  task automatic t_itu_vbi();
    cfg(ppv_pkg::ITU_VBI, 3'h0, 1);
    far.pre(8'h90, 1);
    repeat (6) far.cyc(16'h0040, 3'h0);
    flush();
    far.pre(8'hE0, 1);
    apb(0, ppv_pkg::A_STAT, 32'h0);
    chk(rv[ppv_pkg::S_VBL -: 2], 2'b11, "blank and field");
    far.cyc(16'h0234, 3'h0);
    far.pre(8'h90, 1);
    repeat (8) far.cyc(16'h0040, 3'h0);
    rx(16'h0234, "blanking sample");
    apb(0, ppv_pkg::A_STAT, 32'h0);
    chk({rv[ppv_pkg::S_SOF], rv[ppv_pkg::S_OVR]}, 2'b10, "sof");
  endtask
  task automatic t_itu_all();
    cfg(ppv_pkg::ITU_ALL, 3'h0, 0);
    far.pre(8'h90, 0);
    repeat (8) far.cyc(16'h0010, 3'h0);
    flush();
    repeat (10) far.cyc(16'h0010, 3'h0);
    rx(16'h0010, "blank kept");
    apb(0, ppv_pkg::A_STAT, 32'h0);
    chk(rv[ppv_pkg::S_OVR], 1'b1, "overrun set");
    apb(1, ppv_pkg::A_STAT, 32'h0000_0002);
    apb(0, ppv_pkg::A_STAT, 32'h0);
    chk(rv[ppv_pkg::S_OVR], 1'b0, "overrun clear");
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    // Link ticks during reset too, off phase with the system clock
    fork
      begin
        #7;
        repeat (3) far.cyc(16'h0000, 3'h0);
      end
    join_none
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_gp_in();
    t_capture();
    t_gp_out();
    t_itu_act();
    t_itu_vbi();
    t_itu_all();
    summarize();
  end
endmodule
